// ===== gpdc_pkg.sv
// Purpose: Constants for the pin driver-type and direction configuration block
// Assumes: 32-bit register port, 31 pins
// Notes:   Byte addresses are the printed offsets
package gpdc_pkg;
  localparam int          NPINS          = 31;
  localparam logic [7:0]  OFF_DRV_TYPE   = 8'hA4;
  localparam logic [7:0]  OFF_DIR        = 8'hA8;
  localparam logic [7:0]  OFF_FUNC_SEL   = 8'hA0;
  localparam logic [7:0]  OFF_DATA       = 8'hAC;
  localparam logic [7:0]  OFF_CFG_STATUS = 8'hB0;
  localparam logic [30:0] DRV_TYPE_RST   = 31'h00000000;
  localparam logic [30:0] DIR_RST        = 31'h00000000;
  localparam logic [30:0] FUNC_SEL_RST   = 31'h7FFFFFFF;
  localparam logic [30:0] DATA_RST       = 31'h00000000;
  localparam logic [31:0] UNMAPPED_READ  = 32'h00000000;
  localparam int          BYTE_W         = 8;
  localparam int          NLANES         = 4;
  typedef enum logic [1:0] {
    GPDC_IDLE = 2'b00,
    GPDC_LOAD = 2'b01,
    GPDC_RUN  = 2'b10
  } gpdc_state_t;
endpackage

// ===== gpdc_pin_cell.sv
// Purpose: Output buffer decision for one pin
// Assumes: Settings stable from flip-flops
// Notes:   Outputs registered; enable low means driving
`timescale 1ns/100ps
`default_nettype none
module gpdc_pin_cell (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic func_sel,
  input  wire logic dir_out,
  input  wire logic push_pull,
  input  wire logic data_bit,
  output var  logic pin_o,
  output var  logic pin_oe_n
);
  // ----------------------------------------
  // Drive decision
  // ----------------------------------------
  wire logic gpio_mode;
  wire logic drive_nxt;
  assign gpio_mode = ~func_sel;
  // Open-drain only ever pulls low; driver type matters only as output
  assign drive_nxt = gpio_mode & dir_out & (push_pull | ~data_bit);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_o    <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      pin_o    <= data_bit;
      pin_oe_n <= ~drive_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== gpdc_top.sv
// Purpose: Pin driver-type and direction configuration with register port
// Assumes: Loader presents bytes lane by lane with an image-done pulse
// Notes:   Image shadow holds last EEPROM load for later bus and light resets
//
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module gpdc_top (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  input  wire logic        eeprom_present,
  input  wire logic        cfg_byte_vld,
  input  wire logic [1:0]  cfg_byte_lane,
  input  wire logic [7:0]  driver_type_cfg_byte,
  input  wire logic [7:0]  direction_cfg_byte,
  input  wire logic        cfg_load_done,
  input  wire logic        bus_reset,
  input  wire logic        light_reset,
  input  wire logic [30:0] pin_i,
  output var  logic [30:0] pin_o,
  output var  logic [30:0] pin_oe_n,
  output var  logic        cfg_loaded
);
  // ----------------------------------------
  // State and storage
  // ----------------------------------------
  gpdc_pkg::gpdc_state_t state_r;
  gpdc_pkg::gpdc_state_t state_nxt;
  logic [30:0] pin_driver_type_bits;
  logic [30:0] pin_direction_bits;
  logic [30:0] pin_function_select;
  logic [30:0] pin_data_bits;
  logic [31:0] drv_img_r;
  logic [31:0] dir_img_r;
  logic [31:0] drv_acc_r;
  logic [31:0] dir_acc_r;
  logic        img_valid_r;
  logic [30:0] pin_in_r;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction
  wire logic wr_drv;
  wire logic wr_dir;
  wire logic wr_fsel;
  wire logic wr_data;
  wire logic soft_reset;
  wire logic [30:0] drv_restore;
  wire logic [30:0] dir_restore;
  assign wr_drv     = reg_wr & hit(reg_addr, gpdc_pkg::OFF_DRV_TYPE);
  assign wr_dir     = reg_wr & hit(reg_addr, gpdc_pkg::OFF_DIR);
  assign wr_fsel    = reg_wr & hit(reg_addr, gpdc_pkg::OFF_FUNC_SEL);
  assign wr_data    = reg_wr & hit(reg_addr, gpdc_pkg::OFF_DATA);
  assign soft_reset = bus_reset | light_reset;
  // Without a loaded image the restore value is the plain zero default
  assign drv_restore = img_valid_r ? drv_img_r[30:0] : gpdc_pkg::DRV_TYPE_RST;
  assign dir_restore = img_valid_r ? dir_img_r[30:0] : gpdc_pkg::DIR_RST;

  // ----------------------------------------
  // Image load sequence
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      gpdc_pkg::GPDC_IDLE: begin
        if (eeprom_present)
          state_nxt = gpdc_pkg::GPDC_LOAD;
        else
          state_nxt = gpdc_pkg::GPDC_RUN;
      end
      gpdc_pkg::GPDC_LOAD: begin
        if (cfg_load_done)
          state_nxt = gpdc_pkg::GPDC_RUN;
      end
      gpdc_pkg::GPDC_RUN: state_nxt = gpdc_pkg::GPDC_RUN;
      default: state_nxt = gpdc_pkg::GPDC_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      state_r <= gpdc_pkg::GPDC_IDLE;
    else
      state_r <= state_nxt;
  end

  // One byte per lane, lane 0 lowest
  genvar g;
  generate
    for (g = 0; g < gpdc_pkg::NLANES; g++) begin : g_lane
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          drv_acc_r[g*8 +: 8] <= 8'h00;
          dir_acc_r[g*8 +: 8] <= 8'h00;
        end else if (cfg_byte_vld && state_r == gpdc_pkg::GPDC_LOAD
                     && cfg_byte_lane == 2'(g)) begin
          drv_acc_r[g*8 +: 8] <= driver_type_cfg_byte;
          dir_acc_r[g*8 +: 8] <= direction_cfg_byte;
        end
      end
    end
  endgenerate

  wire logic load_fire;
  assign load_fire = (state_r == gpdc_pkg::GPDC_LOAD) & cfg_load_done;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drv_img_r   <= 32'h00000000;
      dir_img_r   <= 32'h00000000;
      img_valid_r <= 1'b0;
    end else if (load_fire) begin
      drv_img_r   <= drv_acc_r;
      dir_img_r   <= dir_acc_r;
      img_valid_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_driver_type_bits <= gpdc_pkg::DRV_TYPE_RST;
      pin_direction_bits   <= gpdc_pkg::DIR_RST;
      pin_function_select  <= gpdc_pkg::FUNC_SEL_RST;
      pin_data_bits        <= gpdc_pkg::DATA_RST;
    end else if (load_fire) begin
      pin_driver_type_bits <= drv_acc_r[30:0];
      pin_direction_bits   <= dir_acc_r[30:0];
    end else if (soft_reset) begin
      pin_driver_type_bits <= drv_restore;
      pin_direction_bits   <= dir_restore;
      pin_function_select  <= gpdc_pkg::FUNC_SEL_RST;
    end else begin
      // Bit 31 of write data is dropped
      if (wr_drv)  pin_driver_type_bits <= reg_wdata[30:0];
      if (wr_dir)  pin_direction_bits   <= reg_wdata[30:0];
      if (wr_fsel) pin_function_select  <= reg_wdata[30:0];
      if (wr_data) pin_data_bits        <= reg_wdata[30:0];
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  wire logic [31:0] rd_mux;
  assign rd_mux =
    hit(reg_addr, gpdc_pkg::OFF_DRV_TYPE)   ? {1'b0, pin_driver_type_bits} :
    hit(reg_addr, gpdc_pkg::OFF_DIR)        ? {1'b0, pin_direction_bits}   :
    hit(reg_addr, gpdc_pkg::OFF_FUNC_SEL)   ? {1'b0, pin_function_select}  :
    hit(reg_addr, gpdc_pkg::OFF_DATA)       ? {1'b0, pin_in_r}             :
    hit(reg_addr, gpdc_pkg::OFF_CFG_STATUS) ? {30'h00000000, img_valid_r,
                                               state_r == gpdc_pkg::GPDC_RUN} :
    gpdc_pkg::UNMAPPED_READ;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata  <= 32'h00000000;
      pin_in_r   <= 31'h00000000;
      cfg_loaded <= 1'b0;
    end else begin
      reg_rdata  <= reg_rd ? rd_mux : 32'h00000000;
      pin_in_r   <= pin_i;
      cfg_loaded <= (state_nxt == gpdc_pkg::GPDC_RUN);
    end
  end

  // ----------------------------------------
  // Pin cells
  // ----------------------------------------
  generate
    for (g = 0; g < gpdc_pkg::NPINS; g++) begin : g_pin
      gpdc_pin_cell u_cell (
        .clk       (clk),
        .rst       (rst),
        .func_sel  (pin_function_select[g]),
        .dir_out   (pin_direction_bits[g]),
        .push_pull (pin_driver_type_bits[g]),
        .data_bit  (pin_data_bits[g]),
        .pin_o     (pin_o[g]),
        .pin_oe_n  (pin_oe_n[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_drv_write: assert property (@(posedge clk) disable iff (rst)
    wr_drv && !load_fire && !soft_reset |=> pin_driver_type_bits == $past(reg_wdata[30:0]))
    else $error("driver type write lost");
  a_dir_write: assert property (@(posedge clk) disable iff (rst)
    wr_dir && !load_fire && !soft_reset |=> pin_direction_bits == $past(reg_wdata[30:0]))
    else $error("direction write lost");
  a_drv_load: assert property (@(posedge clk) disable iff (rst)
    load_fire |=> pin_driver_type_bits == drv_img_r[30:0])
    else $error("driver type image not loaded");
  a_dir_load: assert property (@(posedge clk) disable iff (rst)
    load_fire |=> pin_direction_bits == dir_img_r[30:0])
    else $error("direction image not loaded");
  a_no_eeprom_zero: assert property (@(posedge clk) disable iff (rst)
    soft_reset && !load_fire && !img_valid_r |=> pin_direction_bits == 31'h00000000
      && pin_driver_type_bits == 31'h00000000)
    else $error("no image reset not zero");
  a_soft_restore: assert property (@(posedge clk) disable iff (rst)
    soft_reset && !load_fire && img_valid_r |=> pin_direction_bits == dir_img_r[30:0])
    else $error("image not restored");
  a_func_hold: assert property (@(posedge clk) disable iff (rst)
    pin_function_select[0] |=> pin_oe_n[0])
    else $error("default function pin driven");
  a_read_top_zero: assert property (@(posedge clk) disable iff (rst)
    reg_rd |=> reg_rdata[31] == 1'b0)
    else $error("bit 31 reads nonzero");
  a_pin_read: assert property (@(posedge clk) disable iff (rst)
    reg_rd && hit(reg_addr, gpdc_pkg::OFF_DATA) |=> reg_rdata[30:0] == $past(pin_in_r))
    else $error("pin state read wrong");
  c_load: cover property (@(posedge clk) disable iff (rst) load_fire);
  c_restore: cover property (@(posedge clk) disable iff (rst) soft_reset && img_valid_r);
  c_drive_pp: cover property (@(posedge clk) disable iff (rst) !pin_oe_n[0] && pin_o[0]);
endmodule
`default_nettype wire

// ===== gpdc_pin_load.sv
// Purpose: Pin loads seen by the configuration block
// Assumes: Every pin has a pull-up
// Notes:   Released pins read one, never the last driven value
`timescale 1ns/100ps
`default_nettype none
module gpdc_pin_load (
  input  wire logic [30:0] pin_o,
  input  wire logic [30:0] pin_oe_n,
  output var  logic [30:0] pin_i
);
  // ----------------------------------------
  // Wire level
  // ----------------------------------------
  // Pull-up wins when released; open-drain high relies on it
  assign pin_i = pin_o | pin_oe_n;
endmodule
`default_nettype wire

// ===== gpdc_top_test.sv
// Purpose: Self-checking bench for the pin configuration block
// Assumes: Register reads answer one cycle after the strobe
// Notes:   Pin loads come from a pull-up model
`timescale 1ns/100ps
`default_nettype none
module gpdc_top_test;
  typedef struct packed {
    logic [30:0] dir;
    logic [30:0] drv;
    logic [30:0] dat;
    logic [30:0] oe;
    logic [30:0] lvl;
  } gpdc_row_t;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        eeprom_present = 1'b0;
  logic        cfg_byte_vld = 1'b0;
  logic [1:0]  cfg_byte_lane = 2'h0;
  logic [7:0]  driver_type_cfg_byte = 8'h00;
  logic [7:0]  direction_cfg_byte = 8'h00;
  logic        cfg_load_done = 1'b0;
  logic        bus_reset = 1'b0;
  logic        light_reset = 1'b0;
  logic [30:0] pin_i;
  logic [30:0] pin_o;
  logic [30:0] pin_oe_n;
  logic        cfg_loaded;
  logic [31:0] d;
  int          errors = 0;
  int          n_compared = 0;
  gpdc_row_t   rows [4] = '{
    '{31'h7FFFFFFF, 31'h7FFFFFFF, 31'h0000FFFF, 31'h00000000, 31'h0000FFFF},
    '{31'h7FFFFFFF, 31'h00000000, 31'h0000FFFF, 31'h0000FFFF, 31'h0000FFFF},
    '{31'h0000FFFF, 31'h00FF00FF, 31'h0F0F0F0F, 31'h7FFF0F00, 31'h7FFF0F0F},
    '{31'h00000000, 31'h7FFFFFFF, 31'h7FFFFFFF, 31'h7FFFFFFF, 31'h7FFFFFFF}};

  always #20 clk = ~clk;

  gpdc_top dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .eeprom_present(eeprom_present), .cfg_byte_vld(cfg_byte_vld),
    .cfg_byte_lane(cfg_byte_lane), .driver_type_cfg_byte(driver_type_cfg_byte),
    .direction_cfg_byte(direction_cfg_byte), .cfg_load_done(cfg_load_done),
    .bus_reset(bus_reset), .light_reset(light_reset), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_n(pin_oe_n), .cfg_loaded(cfg_loaded));
  gpdc_pin_load load_u (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .pin_i(pin_i));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Data sampled after the answer edge settles, before it goes back to zero
  task rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task rst_dut(input logic p);
    rst <= 1'b1; eeprom_present <= p;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task load(input logic [31:0] dv, input logic [31:0] dr);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      cfg_byte_vld <= 1'b1; cfg_byte_lane <= 2'(k);
      driver_type_cfg_byte <= dv[8*k+:8]; direction_cfg_byte <= dr[8*k+:8];
    end
    @(posedge clk);
    cfg_byte_vld <= 1'b0; cfg_load_done <= 1'b1;
    @(posedge clk);
    cfg_load_done <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task results;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  // Whole run is about 125 cycles; watchdog allows 3000 cycles, about 24 times that
  initial begin
    #120000;
    errors++;
    results();
  end
  initial begin
    rst_dut(1'b0);
    #1 chk({1'b0, pin_oe_n}, 32'h7FFFFFFF);
    rd(8'hA4); chk(d, 32'h00000000);
    rd(8'hA8); chk(d, 32'h00000000);
    rd(8'hB0); chk(d, 32'h00000001);
    wr(8'hA0, 32'h00000000);
    for (int i = 0; i < 4; i++) begin
      wr(8'hA4, {1'b1, rows[i].drv});
      wr(8'hA8, {1'b1, rows[i].dir});
      wr(8'hAC, {1'b0, rows[i].dat});
      repeat (2) @(posedge clk);
      #1 chk({1'b0, pin_oe_n}, {1'b0, rows[i].oe});
      chk({1'b0, pin_i}, {1'b0, rows[i].lvl});
      rd(8'hA4); chk(d, {1'b0, rows[i].drv});
      rd(8'hA8); chk(d, {1'b0, rows[i].dir});
      rd(8'hAC); chk(d, {1'b0, rows[i].lvl});
    end
    rd(8'h10); chk(d, 32'h00000000);
    rst_dut(1'b1);
    load(32'hA3A2A1A0, 32'hD3525150);
    chk({31'h0, cfg_loaded}, 32'h1);
    rd(8'hB0); chk(d, 32'h00000003);
    rd(8'hA4); chk(d, 32'h23A2A1A0);
    rd(8'hA8); chk(d, 32'h53525150);
    chk({1'b0, pin_oe_n}, 32'h7FFFFFFF);
    for (int j = 0; j < 2; j++) begin
      wr(8'hA4, 32'h00000000);
      wr(8'hA8, 32'h0000FFFF);
      @(posedge clk);
      if (j == 0) light_reset <= 1'b1;
      else bus_reset <= 1'b1;
      @(posedge clk);
      light_reset <= 1'b0; bus_reset <= 1'b0;
      rd(8'hA4); chk(d, 32'h23A2A1A0);
      rd(8'hA8); chk(d, 32'h53525150);
    end
    rst_dut(1'b0);
    wr(8'hA4, 32'h7FFFFFFF);
    @(posedge clk);
    bus_reset <= 1'b1;
    @(posedge clk);
    bus_reset <= 1'b0;
    rd(8'hA4); chk(d, 32'h00000000);
    results();
  end
endmodule
`default_nettype wire
